// ===== ccdvp_timing.sv
// CCD vertical pattern generator with blanking clock width and clamp masking
//
// Behaviour
// - Three-bit blanking clock width setting provided
// - Codes 0-4, 7: rates 1 to 1/14
// - Codes 5 and 6: rate 1/10, 1/12
// - Reduced rate only inside horizontal blanking
// - Clamp mask lines suppress clamp pulse only
// - Thirteen individually programmable vertical outputs
// - Patterns, sequences, field regions, mode hierarchy
// - Up to nine regions, each picks sequence
// - Counts bounded by implemented register sets
// - Mode combines fields in any order
// - Six toggle positions per output per group
// - Toggle positions are 13-bit pixel locations
// - Output starts at its programmed polarity
// - Pattern begins at programmed start pixel
// - Pattern length sets span of the toggle window
// - Toggles at pixel 0 or 8191 ignored
// - Pattern toggle storage has no reset
`timescale 1ns/1ps
`default_nettype none
module ccdvp_timing
    import ccdvp_pkg::*;
(
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    // Decoded serial register port
    input  wire logic                      cfg_wr,
    input  wire logic                      cfg_rd,
    input  wire logic [CCDVP_ADDR_W-1:0]   cfg_addr,
    input  wire logic [CCDVP_DATA_W-1:0]   cfg_wdata,
    output logic      [CCDVP_DATA_W-1:0]   cfg_rdata,
    // Sensor clocks
    output logic      [CCDVP_NUM_XV-1:0]   vertical_transfer_outputs,
    output logic                           horizontal_ccd_clock_one,
    output logic                           horizontal_ccd_clock_four,
    output logic                           horizontal_blanking,
    output logic                           optical_black_clamp
);
    // Configuration registers
    logic [2:0]  blanking_hclock_width_field_reg, blanking_hclock_width_field_next;
    logic [12:0] pol_reg [CCDVP_NUM_GRP], pol_next [CCDVP_NUM_GRP];
    logic [12:0] pattern_start_pixel_reg [CCDVP_NUM_GRP], pattern_start_pixel_next [CCDVP_NUM_GRP];
    logic [12:0] pattern_total_length_reg [CCDVP_NUM_GRP], pattern_total_length_next [CCDVP_NUM_GRP];
    logic [12:0] hdlen_reg, hdlen_next, blank_on_reg, blank_on_next, blank_off_reg, blank_off_next;
    logic [12:0] clamp_on_reg, clamp_on_next, clamp_off_reg, clamp_off_next;
    logic [11:0] clamp_mask_first_line_reg, clamp_mask_first_line_next;
    logic [11:0] clamp_mask_last_line_reg, clamp_mask_last_line_next;
    logic [11:0] fldlen_reg, fldlen_next;
    logic [5:0]  mode_reg, mode_next;
    logic [12:0] region_reg [CCDVP_NUM_FLD][CCDVP_NUM_REG], region_next [CCDVP_NUM_FLD][CCDVP_NUM_REG];
    logic [12:0] tog_reg [CCDVP_NUM_GRP][CCDVP_NUM_XV][CCDVP_NUM_TOG]; // One set per implemented group
    logic [31:0] rdata_reg, rdata_next;

    // Timing state
    logic [12:0] pix_reg, pix_next;
    logic [11:0] line_reg, line_next;
    logic [1:0]  slot_reg, slot_next;
    logic [3:0]  div_cnt_reg, div_cnt_next;
    logic        hph_reg, hph_next, hph4_reg, hph4_next, blank_reg, blank_next, clamp_reg, clamp_next;
    logic [12:0] xv_reg, xv_next;

    // Derived terms
    logic        line_end, field_end, in_blank, in_pat, pat_start, grp_sel, masked;
    logic [12:0] rel_pix;
    logic [3:0]  div_half;
    logic        field_id;
    logic [12:0] sel_pol;

    // Configuration write decode; toggles are a separate unreset store
    always_comb begin
        blanking_hclock_width_field_next = blanking_hclock_width_field_reg;
        hdlen_next                 = hdlen_reg;
        blank_on_next              = blank_on_reg;
        blank_off_next             = blank_off_reg;
        clamp_on_next              = clamp_on_reg;
        clamp_off_next             = clamp_off_reg;
        clamp_mask_first_line_next = clamp_mask_first_line_reg;
        clamp_mask_last_line_next  = clamp_mask_last_line_reg;
        fldlen_next                = fldlen_reg;
        mode_next                  = mode_reg;
        pol_next                   = pol_reg;
        pattern_start_pixel_next   = pattern_start_pixel_reg;
        pattern_total_length_next  = pattern_total_length_reg;
        region_next                = region_reg;
        if (cfg_wr) begin
            case (cfg_addr)
                CCDVP_OFS_WIDTH:  blanking_hclock_width_field_next = cfg_wdata[CCDVP_WIDTH_LSB +: 3];
                CCDVP_OFS_HDLEN:  hdlen_next = cfg_wdata[12:0];
                CCDVP_OFS_BLANK: begin
                    blank_on_next  = cfg_wdata[12:0];
                    blank_off_next = cfg_wdata[CCDVP_HI_LSB +: 13];
                end
                CCDVP_OFS_CLAMP: begin
                    clamp_on_next  = cfg_wdata[12:0];
                    clamp_off_next = cfg_wdata[CCDVP_HI_LSB +: 13];
                end
                CCDVP_OFS_CMASK: begin
                    clamp_mask_first_line_next = cfg_wdata[11:0];
                    clamp_mask_last_line_next  = cfg_wdata[CCDVP_HI_LSB +: 12];
                end
                CCDVP_OFS_FLDLEN: fldlen_next = cfg_wdata[11:0];
                CCDVP_OFS_MODE:   mode_next = cfg_wdata[5:0];
                default: ;
            endcase
            for (int g = 0; g < CCDVP_NUM_GRP; g++) begin
                if (cfg_addr == CCDVP_OFS_POL + 10'(g))    pol_next[g] = cfg_wdata[12:0];
                if (cfg_addr == CCDVP_OFS_PSTART + 10'(g)) pattern_start_pixel_next[g] = cfg_wdata[12:0];
                if (cfg_addr == CCDVP_OFS_PLEN + 10'(g))   pattern_total_length_next[g] = cfg_wdata[12:0];
            end
            for (int f = 0; f < CCDVP_NUM_FLD; f++) begin
                for (int r = 0; r < CCDVP_NUM_REG; r++) begin
                    if (cfg_addr == CCDVP_OFS_REGION + 10'(f * CCDVP_REGION_STEP + r))
                        region_next[f][r] = cfg_wdata[12:0];
                end
            end
        end
    end

    // Configuration registers with defined reset
    always_ff @(posedge clk) begin
        if (rst) begin
            blanking_hclock_width_field_reg <= CCDVP_RST_WIDTH;
            hdlen_reg                 <= CCDVP_RST_HDLEN;
            blank_on_reg              <= CCDVP_RST_ZERO13;
            blank_off_reg             <= CCDVP_RST_ZERO13;
            clamp_on_reg              <= CCDVP_RST_ZERO13;
            clamp_off_reg             <= CCDVP_RST_ZERO13;
            clamp_mask_first_line_reg <= CCDVP_RST_ZERO12;
            clamp_mask_last_line_reg  <= CCDVP_RST_ZERO12;
            fldlen_reg                <= CCDVP_RST_FLDLEN;
            mode_reg                  <= CCDVP_RST_MODE;
            for (int g = 0; g < CCDVP_NUM_GRP; g++) begin
                pol_reg[g]                  <= CCDVP_RST_ZERO13;
                pattern_start_pixel_reg[g]  <= CCDVP_RST_ZERO13;
                pattern_total_length_reg[g] <= CCDVP_RST_ZERO13;
            end
            for (int f = 0; f < CCDVP_NUM_FLD; f++) begin
                for (int r = 0; r < CCDVP_NUM_REG; r++) region_reg[f][r] <= CCDVP_RST_ZERO13;
            end
        end else begin
            blanking_hclock_width_field_reg <= blanking_hclock_width_field_next;
            hdlen_reg                 <= hdlen_next;
            blank_on_reg              <= blank_on_next;
            blank_off_reg             <= blank_off_next;
            clamp_on_reg              <= clamp_on_next;
            clamp_off_reg             <= clamp_off_next;
            clamp_mask_first_line_reg <= clamp_mask_first_line_next;
            clamp_mask_last_line_reg  <= clamp_mask_last_line_next;
            fldlen_reg                <= fldlen_next;
            mode_reg                  <= mode_next;
            pol_reg                   <= pol_next;
            pattern_start_pixel_reg   <= pattern_start_pixel_next;
            pattern_total_length_reg  <= pattern_total_length_next;
            region_reg                <= region_next;
        end
    end

    // Toggle store: no reset, contents unknown until written
    generate
        for (genvar g = 0; g < CCDVP_NUM_GRP; g++) begin : g_grp
            for (genvar c = 0; c < CCDVP_NUM_XV; c++) begin : g_ch
                for (genvar k = 0; k < CCDVP_NUM_TOG; k++) begin : g_tog
                    localparam logic [9:0] TOG_ADDR =
                        10'(CCDVP_OFS_TOG + g * CCDVP_TOG_GSTEP + c * CCDVP_TOG_CSTEP + k);
                    always_ff @(posedge clk) begin
                        if (cfg_wr && cfg_addr == TOG_ADDR) tog_reg[g][c][k] <= cfg_wdata[12:0];
                    end
                end
            end
        end
    endgenerate

    // Line, field and mode slot position
    assign line_end  = (pix_reg >= hdlen_reg);
    assign field_end = line_end && (line_reg >= fldlen_reg);
    assign field_id  = mode_reg[CCDVP_MODE_ID_LSB + 32'(slot_reg)];

    // Region lookup: highest region whose start line has been reached
    always_comb begin
        grp_sel = region_reg[field_id][0][CCDVP_REGSEL_BIT];
        for (int r = 1; r < CCDVP_NUM_REG; r++) begin
            if (line_reg >= region_reg[field_id][r][11:0] && region_reg[field_id][r][11:0] != CCDVP_RST_ZERO12)
                grp_sel = region_reg[field_id][r][CCDVP_REGSEL_BIT];
        end
    end

    // Pattern window of the selected group
    assign sel_pol   = pol_reg[grp_sel];
    assign rel_pix   = pix_reg - pattern_start_pixel_reg[grp_sel];
    assign pat_start = (pix_reg == pattern_start_pixel_reg[grp_sel]);
    assign in_pat    = (pix_reg >= pattern_start_pixel_reg[grp_sel]) &&
                       (rel_pix < pattern_total_length_reg[grp_sel]);

    // Blanking window, divider ratio and clamp mask
    assign in_blank = (pix_reg >= blank_on_reg) && (pix_reg < blank_off_reg);
    assign div_half = CCDVP_DIV_TABLE[blanking_hclock_width_field_reg];
    assign masked   = (line_reg >= clamp_mask_first_line_reg) && (line_reg <= clamp_mask_last_line_reg);

    // Counters and horizontal outputs
    always_comb begin
        pix_next     = line_end ? CCDVP_RST_ZERO13 : pix_reg + 13'h0001;
        line_next    = line_reg;
        slot_next    = slot_reg;
        if (line_end) begin
            line_next = field_end ? CCDVP_RST_ZERO12 : line_reg + 12'h001;
            if (field_end)
                slot_next = (slot_reg >= mode_reg[1:0]) ? 2'h0 : slot_reg + 2'h1;
        end
        blank_next   = in_blank;
        div_cnt_next = 4'h1;
        hph_next     = ~hph_reg;
        if (in_blank) begin
            if (!blank_reg) begin
                div_cnt_next = 4'h1;
                hph_next     = ~hph_reg;
            end else if (div_cnt_reg >= div_half) begin
                div_cnt_next = 4'h1;
                hph_next     = ~hph_reg;
            end else begin
                div_cnt_next = div_cnt_reg + 4'h1;
                hph_next     = hph_reg;
            end
        end
        clamp_next   = (pix_reg >= clamp_on_reg) && (pix_reg < clamp_off_reg) && !masked;
        hph4_next    = ~hph_next; // Own flop, so no inverter sits behind the pin
    end

    // Vertical outputs: polarity at start, invert at each valid toggle
    generate
        for (genvar c = 0; c < CCDVP_NUM_XV; c++) begin : g_xv
            logic hit;
            always_comb begin
                hit = 1'b0;
                for (int k = 0; k < CCDVP_NUM_TOG; k++) begin
                    if (tog_reg[grp_sel][c][k] == rel_pix &&
                        tog_reg[grp_sel][c][k] != CCDVP_TOG_OFF_LO &&
                        tog_reg[grp_sel][c][k] != CCDVP_TOG_OFF_HI)
                        hit = 1'b1;
                end
                if (pat_start)
                    xv_next[c] = sel_pol[c];
                else if (in_pat && hit)
                    xv_next[c] = ~xv_reg[c];
                else
                    xv_next[c] = xv_reg[c];
            end
        end
    endgenerate

    // Status read: position of the timing core, and width readback
    always_comb begin
        rdata_next = rdata_reg;
        if (cfg_rd) begin
            case (cfg_addr)
                CCDVP_OFS_WIDTH:  rdata_next = {25'h0, blanking_hclock_width_field_reg, 4'h0};
                CCDVP_OFS_STATUS: rdata_next = {1'b0, grp_sel, slot_reg, line_reg, 3'h0, pix_reg};
                default:          rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // Timing and output flops
    always_ff @(posedge clk) begin
        if (rst) begin
            pix_reg     <= CCDVP_RST_ZERO13;
            line_reg    <= CCDVP_RST_ZERO12;
            slot_reg    <= 2'h0;
            div_cnt_reg <= 4'h1;
            hph_reg     <= 1'b0;
            hph4_reg    <= 1'b1;
            blank_reg   <= 1'b0;
            clamp_reg   <= 1'b0;
            xv_reg      <= CCDVP_RST_ZERO13;
            rdata_reg   <= 32'h0000_0000;
        end else begin
            pix_reg     <= pix_next;
            line_reg    <= line_next;
            slot_reg    <= slot_next;
            div_cnt_reg <= div_cnt_next;
            hph_reg     <= hph_next;
            hph4_reg    <= hph4_next;
            blank_reg   <= blank_next;
            clamp_reg   <= clamp_next;
            xv_reg      <= xv_next;
            rdata_reg   <= rdata_next;
        end
    end

    // Outputs straight from flops; clock four is the complement phase
    assign cfg_rdata                 = rdata_reg;
    assign vertical_transfer_outputs = xv_reg;
    assign horizontal_ccd_clock_one  = hph_reg;
    assign horizontal_ccd_clock_four = hph4_reg;
    assign horizontal_blanking       = blank_reg;
    assign optical_black_clamp       = clamp_reg;

    // Checks
    a_hclk_full_rate: assert property (@(posedge clk) disable iff (rst)
        !in_blank |=> hph_reg != $past(hph_reg)) else $error("H clock not at pixel rate");
    a_div_restart: assert property (@(posedge clk) disable iff (rst)
        in_blank && !blank_reg |=> div_cnt_reg == 4'h1) else $error("Divider not restarted");
    a_div_half: assert property (@(posedge clk) disable iff (rst)
        in_blank && blank_reg && blanking_hclock_width_field_reg == 3'h1 && div_cnt_reg == 4'h1 && !$past(rst)
        |=> hph_reg == $past(hph_reg)) else $error("Half rate hold missing");
    a_div_table: assert property (@(posedge clk) disable iff (rst)
        in_blank && blank_reg && blanking_hclock_width_field_reg == 3'h5 && div_cnt_reg < 4'hA
        |=> hph_reg == $past(hph_reg)) else $error("Tenth rate wrong");
    a_clamp_mask: assert property (@(posedge clk) disable iff (rst)
        masked |=> !optical_black_clamp) else $error("Clamp not masked");
    a_clamp_pass: assert property (@(posedge clk) disable iff (rst)
        !masked && pix_reg == clamp_on_reg && clamp_on_reg < clamp_off_reg |=> optical_black_clamp)
        else $error("Clamp lost on unmasked line");
    a_xv_polarity: assert property (@(posedge clk) disable iff (rst)
        pat_start |=> vertical_transfer_outputs == $past(sel_pol)) else $error("Start polarity wrong");
    a_xv_idle: assert property (@(posedge clk) disable iff (rst)
        !in_pat && !pat_start |=> vertical_transfer_outputs == $past(xv_reg)) else $error("Toggle outside pattern");
    a_width_read: assert property (@(posedge clk) disable iff (rst)
        cfg_rd && cfg_addr == CCDVP_OFS_WIDTH |=> cfg_rdata[6:4] == $past(blanking_hclock_width_field_reg))
        else $error("Width readback wrong");
    a_line_wrap: assert property (@(posedge clk) disable iff (rst)
        line_end |=> pix_reg == 13'h0000) else $error("Line did not wrap");
    c_blank_div: cover property (@(posedge clk) disable iff (rst)
        in_blank && blanking_hclock_width_field_reg == 3'h7 ##1 in_blank [*8]);
    c_pattern_run: cover property (@(posedge clk) disable iff (rst) pat_start ##[1:200] in_pat && !pat_start);
    c_field_wrap: cover property (@(posedge clk) disable iff (rst) field_end && slot_reg == 2'h1);
endmodule
`default_nettype wire

// ===== ccdvp_pkg.sv
// Constants for the CCD vertical pattern and horizontal blanking timing block
`default_nettype none
package ccdvp_pkg;
    // Geometry
    localparam int          CCDVP_NUM_XV      = 13;
    localparam int          CCDVP_NUM_TOG     = 6;
    localparam int          CCDVP_NUM_GRP     = 2;
    localparam int          CCDVP_NUM_FLD     = 2;
    localparam int          CCDVP_NUM_REG     = 9;
    localparam int          CCDVP_NUM_SLOT    = 4;
    localparam int          CCDVP_PIX_W       = 13;
    localparam int          CCDVP_LINE_W      = 12;
    localparam int          CCDVP_ADDR_W      = 10;
    localparam int          CCDVP_DATA_W      = 32;
    // Toggle values that never produce a transition
    localparam logic [12:0] CCDVP_TOG_OFF_LO  = 13'h0000;
    localparam logic [12:0] CCDVP_TOG_OFF_HI  = 13'h1FFF;
    // Register offsets (word addresses of the serial register port)
    localparam logic [9:0]  CCDVP_OFS_WIDTH   = 10'h035;
    localparam logic [9:0]  CCDVP_OFS_POL     = 10'h100;
    localparam logic [9:0]  CCDVP_OFS_PSTART  = 10'h102;
    localparam logic [9:0]  CCDVP_OFS_PLEN    = 10'h104;
    localparam logic [9:0]  CCDVP_OFS_HDLEN   = 10'h110;
    localparam logic [9:0]  CCDVP_OFS_BLANK   = 10'h111;
    localparam logic [9:0]  CCDVP_OFS_CLAMP   = 10'h112;
    localparam logic [9:0]  CCDVP_OFS_CMASK   = 10'h113;
    localparam logic [9:0]  CCDVP_OFS_FLDLEN  = 10'h114;
    localparam logic [9:0]  CCDVP_OFS_MODE    = 10'h115;
    localparam logic [9:0]  CCDVP_OFS_STATUS  = 10'h116;
    localparam logic [9:0]  CCDVP_OFS_REGION  = 10'h120;
    localparam logic [9:0]  CCDVP_OFS_TOG     = 10'h200;
    localparam int          CCDVP_REGION_STEP = 16;
    localparam int          CCDVP_TOG_GSTEP   = 128;
    localparam int          CCDVP_TOG_CSTEP   = 8;
    // Field positions
    localparam int          CCDVP_WIDTH_LSB   = 4;
    localparam int          CCDVP_HI_LSB      = 16;
    localparam int          CCDVP_REGSEL_BIT  = 12;
    localparam int          CCDVP_MODE_ID_LSB = 2;
    // Reset values
    localparam logic [2:0]  CCDVP_RST_WIDTH   = 3'h0;
    localparam logic [12:0] CCDVP_RST_HDLEN   = 13'h1FFF;
    localparam logic [11:0] CCDVP_RST_FLDLEN  = 12'hFFF;
    localparam logic [12:0] CCDVP_RST_ZERO13  = 13'h0000;
    localparam logic [11:0] CCDVP_RST_ZERO12  = 12'h000;
    localparam logic [5:0]  CCDVP_RST_MODE    = 6'h00;
    // Blanking clock half-period, in pixel cycles, per width code
    localparam logic [3:0]  CCDVP_DIV_TABLE [8] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hA, 4'hC, 4'hE};
endpackage
`default_nettype wire

// ===== ccdvp_sensor_model.sv
// Sensor-side model counting line shifts driven on the first vertical phase
`timescale 1ns/1ps
`default_nettype none
module ccdvp_sensor_model
    import ccdvp_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Vertical clocks from the timing block
    input  wire logic [CCDVP_NUM_XV-1:0] vertical_transfer_outputs,
    // Observed shift count
    output logic      [15:0]             rise_cnt
);
    logic prev_reg;
    // A line moves on each rising edge; unknown levels before setup never count
    always_ff @(posedge clk) begin
        if (rst) begin
            prev_reg <= 1'b0;
            rise_cnt <= 16'h0000;
        end else begin
            prev_reg <= vertical_transfer_outputs[0];
            if (vertical_transfer_outputs[0] && !prev_reg) begin
                rise_cnt <= rise_cnt + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// ===== ccdvp_timing_tb_top.sv
// Testbench for the CCD vertical pattern and blanking clock timing block
`timescale 1ns/1ps
`default_nettype none
module ccdvp_timing_tb_top
    import ccdvp_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cfg_wr = 1'b0;
    logic        cfg_rd = 1'b0;
    logic [9:0]  cfg_addr = 10'h000;
    logic [31:0] cfg_wdata = 32'h0000_0000;
    logic [31:0] cfg_rdata;
    logic [12:0] vertical_transfer_outputs;
    logic        horizontal_ccd_clock_one;
    logic        horizontal_ccd_clock_four;
    logic        horizontal_blanking;
    logic        optical_black_clamp;
    logic [15:0] rise_cnt;
    logic [32:0] smp [0:703];
    logic [12:0] tog0 [6] = '{13'h0003, 13'h0008, 13'h000C, 13'h0016, 13'h0000, 13'h1FFF};
    int          err_total = 0;
    int          num_checks = 0;

    ccdvp_timing ccdvp_timing_inst (.clk(clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .vertical_transfer_outputs(vertical_transfer_outputs),
        .horizontal_ccd_clock_one(horizontal_ccd_clock_one),
        .horizontal_ccd_clock_four(horizontal_ccd_clock_four),
        .horizontal_blanking(horizontal_blanking), .optical_black_clamp(optical_black_clamp));
    ccdvp_sensor_model ccdvp_sensor_model_inst (.clk(clk), .rst(rst),
        .vertical_transfer_outputs(vertical_transfer_outputs), .rise_cnt(rise_cnt));

    // Pixel clock, 4 ns period
    always #2 clk = ~clk;

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One-cycle strobes launched on the falling edge
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(negedge clk);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] exp, input string nm);
        @(negedge clk);
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(negedge clk);
        cfg_rd = 1'b0;
        @(negedge clk);
        chk(nm, cfg_rdata, exp);
    endtask

    // Capture from blanking entry; bits are blanking, count, clamp, phase four, phase one, vertical
    task automatic cap(input int n);
        @(posedge horizontal_blanking);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            smp[i] = {horizontal_blanking, rise_cnt, optical_black_clamp, horizontal_ccd_clock_four,
                      horizontal_ccd_clock_one, vertical_transfer_outputs};
        end
    endtask

    // Watchdog, far beyond the roughly 2200 cycles the run needs
    initial begin
        #200000;
        err_total++;
        close_out();
    end

    initial begin
        logic [12:0] tv;
        int          half;
        int          bad;
        int          m0;
        int          ccnt [10];
        logic        chg;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        rd(CCDVP_OFS_WIDTH, 32'h0000_0000, "width_reset");
        rd(10'h3FF, 32'h0000_0000, "unmapped_read");
        // Line of 64 pixels, five lines, blanking 30..59, clamp 40..49, lines 1-2 masked
        wr(CCDVP_OFS_HDLEN, 32'h0000_003F);
        wr(CCDVP_OFS_FLDLEN, 32'h0000_0004);
        wr(CCDVP_OFS_BLANK, 32'h003C_001E);
        wr(CCDVP_OFS_CLAMP, 32'h0032_0028);
        wr(CCDVP_OFS_CMASK, 32'h0002_0001);
        wr(CCDVP_OFS_POL, 32'h0000_0001);
        for (int g = 0; g < 2; g++) begin
            wr(10'(CCDVP_OFS_PSTART + g), 32'h0000_0005);
            wr(10'(CCDVP_OFS_PLEN + g), 32'h0000_0014);
            for (int c = 0; c < 13; c++) begin
                for (int k = 0; k < 6; k++) begin
                    tv = (g == 0 && c == 0) ? tog0[k] : 13'h1FFF;
                    if (g == 1 && c == 0 && k == 0) tv = 13'h0006;
                    wr(10'(CCDVP_OFS_TOG + g * CCDVP_TOG_GSTEP + c * CCDVP_TOG_CSTEP + k), {19'h00000, tv});
                end
            end
        end
        // Field 0 uses group 0 on lines 0-1 and group 1 from line 2
        wr(CCDVP_OFS_REGION, 32'h0000_0000);
        wr(10'(CCDVP_OFS_REGION + 1), 32'h0000_1002);
        wr(CCDVP_OFS_MODE, 32'h0000_0000);
        for (int w = 0; w < 8; w++) begin
            wr(CCDVP_OFS_WIDTH, 32'(w) << CCDVP_WIDTH_LSB);
            cap(64);
            half = (w == 0) ? 1 : 2 * w;
            bad = 0;
            for (int k = 1; k < 64; k++) begin
                chg = smp[k][13] ^ smp[k-1][13];
                if (smp[k][14] !== ~smp[k][13]) bad++;
                if (smp[k][32] !== (k < 30)) bad++;
                if (k < 30 && chg !== ((k % half) == 0)) bad++;
                if (k > 30 && chg !== 1'b1) bad++;
            end
            chk("hclk_rate", bad, 0);
        end
        wr(10'h3FE, 32'h0000_0010);
        rd(CCDVP_OFS_WIDTH, 32'h0000_0070, "width_readback");
        // Ten full lines; line m holds pixel q at index 34 + 64*m + q
        cap(704);
        m0 = 0;
        for (int m = 0; m < 10; m++) begin
            ccnt[m] = 0;
            for (int q = 40; q < 50; q++) ccnt[m] += int'(smp[34 + 64 * m + q][15]);
        end
        for (int m = 4; m >= 0; m--) begin
            if (ccnt[m] != 0 && ccnt[m+1] == 0) m0 = m;
        end
        for (int j = 0; j < 5; j++) begin
            chk("clamp_cycles", ccnt[m0+j], (j == 1 || j == 2) ? 10 - 10 : 10);
            chk("xv0_pix11", smp[34 + 64 * (m0 + j) + 11][0], j >= 2);
            chk("xv_idle", smp[34 + 64 * (m0 + j) + 20][12:1], 0);
        end
        bad = 0;
        for (int q = 0; q < 64; q++) begin
            if (smp[34 + 64 * (m0 + 1) + q][0] !== ((q >= 5 && q < 8) || (q >= 13 && q < 17))) bad++;
        end
        chk("xv0_line", bad, 0);
        chk("shifts", smp[34 + 64 * (m0 + 5) - 1][31:16] - smp[34 + 64 * m0 - 1][31:16], 6);
        close_out();
    end
endmodule
`default_nettype wire
